//--- design/scr_channel_config.v
// Channel setup registers, reply selection and fault buffers for four satellite channels.
`timescale 1ns/100ps
`include "scr_map.vh"
module scr_channel_config (
	// Clock and reset.
	input  wire        sys_clk,
	input  wire        rst_n,
	// Satellite serial port.
	input  wire        satCsN,
	input  wire        satSclk,
	input  wire        satMosi,
	input  wire [1:0]  satChanSel,
	output reg         satMiso,
	// Fault and data stream from the decoders.
	input  wire        faultValid,
	input  wire        faultGlobal,
	input  wire [1:0]  faultChan,
	input  wire [11:0] faultCode,
	output wire        faultReady,
	// Per-channel and master settings to the decoders.
	output reg  [7:0]  chanRate,
	output reg  [7:0]  chanFieldLen,
	output reg  [7:0]  chanCtl,
	output reg  [12:0] masterCfg
);
	localparam [2:0] ST_SHIFT  = 3'h1;
	localparam [2:0] ST_COMMIT = 3'h2;
	localparam [2:0] ST_DRAIN  = 3'h4;

	function [1:0] statusOf;
		input [1:0] ctl;
		begin
			case (ctl)
				2'h1:    statusOf = `SCR_ST_ON_IDLE;
				2'h2:    statusOf = `SCR_ST_ON_RUN;
				default: statusOf = `SCR_ST_OFF;
			endcase
		end
	endfunction

	function oddPar;
		input [14:0] v;
		begin
			oddPar = ~^v;
		end
	endfunction

	// Synchronisers for the serial pins.
	reg         csMeta_r;
	reg         csSync_r;
	reg         csPrev_r;
	reg         sclkMeta_r;
	reg         sclkSync_r;
	reg         sclkPrev_r;
	reg         mosiMeta_r;
	reg         mosiSync_r;
	reg  [1:0]  chMeta_r;
	reg  [1:0]  chSync_r;

	// Frame and reply state.
	reg  [2:0]  state_r;
	reg  [15:0] rx_r;
	reg  [4:0]  bitCnt_r;
	reg  [15:0] shift_r;
	reg  [1:0]  frameChan_r;
	reg  [1:0]  pendKind_r;
	reg  [1:0]  pendChan_r;
	reg  [1:0]  curKind_r;
	reg  [1:0]  curChan_r;
	reg         curLost_r;

	// Registers and channel buffers.
	reg  [13:0] ccr_r [0:3];
	reg  [12:0] mcr_r;
	reg  [11:0] fifoMem_r [0:7];
	reg  [1:0]  fifoCnt_r [0:3];
	reg  [3:0]  fifoRd_r;
	reg  [3:0]  lost_r;
	reg  [31:0] globalSeen_r;

	// Combinational decode.
	reg  [13:0] wrMask;
	reg  [13:0] ccrCur;
	reg  [13:0] ccr_nxt;
	reg  [1:0]  cmdMode;
	reg  [1:0]  kind_nxt;
	reg  [13:0] repCcr;
	reg  [11:0] repData;
	reg  [1:0]  repStat;
	reg  [15:0] repWord;
	reg  [1:0]  dCh;
	reg  [2:0]  dSlot;
	reg         dDrop;
	wire        csFall;
	wire        csRise;
	wire        sclkRise;
	wire        sclkFall;
	wire        frameOk;
	wire        stgValid;
	wire        stgReady;
	wire [14:0] stgData;
	integer     c;

	assign csFall   = csPrev_r & ~csSync_r;
	assign csRise   = ~csPrev_r & csSync_r;
	assign sclkRise = ~sclkPrev_r & sclkSync_r;
	assign sclkFall = sclkPrev_r & ~sclkSync_r;
	assign frameOk  = (bitCnt_r == `SCR_CMD_BITS);
	// Staged words move only between frames, so a push never meets a pop or a flush.
	assign stgReady = state_r[2] & ~csFall;

	scr_stage_fifo #(
		.W  (`SCR_STG_WIDTH),
		.D  (`SCR_STG_DEPTH),
		.AW (`SCR_STG_AW)
	) u_stage (
		.clk      (sys_clk),
		.rst_n    (rst_n),
		.inValid  (faultValid),
		.inReady  (faultReady),
		.inData   ({faultGlobal, faultChan, faultCode}),
		.outValid (stgValid),
		.outReady (stgReady),
		.outData  (stgData)
	);

	// Command decode used at the end of a frame.
	always @* begin
		ccrCur  = ccr_r[frameChan_r];
		wrMask  = rx_r[`SCR_MASK_BIT] ? `SCR_MASK1_BITS : `SCR_MASK0_BITS;
		ccr_nxt = (ccrCur & ~wrMask) | (rx_r[13:0] & wrMask);
		cmdMode = rx_r[`SCR_SEL_BIT] ? ccr_nxt[`SCR_MODE_HI:`SCR_MODE_LO] : ccrCur[`SCR_MODE_HI:`SCR_MODE_LO];
		case (cmdMode)
			`SCR_MODE_AUTO: begin
				if (rx_r[`SCR_SEL_BIT])
					kind_nxt = `SCR_KIND_CCR;
				else if (frameChan_r == 2'h0)
					kind_nxt = `SCR_KIND_MCR;
				else
					kind_nxt = `SCR_KIND_FILL;
			end
			`SCR_MODE_MASTER: begin
				kind_nxt = (frameChan_r == 2'h0) ? `SCR_KIND_MCR : `SCR_KIND_FILL;
			end
			`SCR_MODE_CHANNEL: begin
				kind_nxt = `SCR_KIND_CCR;
			end
			default: begin
				kind_nxt = `SCR_KIND_FIFO;
			end
		endcase
	end

	// Reply word built from the pending kind at the start of a frame.
	always @* begin
		repCcr  = ccr_r[pendChan_r];
		repStat = statusOf(repCcr[`SCR_CTL_HI:`SCR_CTL_LO]);
		if (fifoCnt_r[pendChan_r] != 2'h0)
			repData = fifoMem_r[{pendChan_r, fifoRd_r[pendChan_r]}];
		else
			repData = `SCR_EMPTY_DATA;
		case (pendKind_r)
			`SCR_KIND_MCR: begin
				repWord = {`SCR_ST_CFG, oddPar({`SCR_ST_CFG, mcr_r}), mcr_r};
			end
			`SCR_KIND_CCR: begin
				repWord = {`SCR_ST_CFG, oddPar({`SCR_ST_CFG, repCcr[12:0]}), repCcr[12:0]};
			end
			`SCR_KIND_FILL: begin
				repWord = `SCR_FILLER;
			end
			default: begin
				repWord = {repStat, oddPar({repStat, lost_r[pendChan_r], repData}), lost_r[pendChan_r], repData};
			end
		endcase
	end

	// Target of a staged word: global codes land on channel 1 once each.
	always @* begin
		dCh   = stgData[14] ? 2'h0 : stgData[13:12];
		dSlot = {dCh, fifoRd_r[dCh] ^ fifoCnt_r[dCh][0]};
		dDrop = stgData[14] & (globalSeen_r[stgData[4:0]] | (stgData[11:0] < `SCR_FAULT_MIN) |
			(stgData[11:0] > `SCR_FAULT_MAX));
	end

	// Pin synchronisers.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			csMeta_r   <= 1'b1;
			csSync_r   <= 1'b1;
			csPrev_r   <= 1'b1;
			sclkMeta_r <= 1'b0;
			sclkSync_r <= 1'b0;
			sclkPrev_r <= 1'b0;
			mosiMeta_r <= 1'b0;
			mosiSync_r <= 1'b0;
			chMeta_r   <= 2'h0;
			chSync_r   <= 2'h0;
		end else begin
			csMeta_r   <= satCsN;
			csSync_r   <= csMeta_r;
			csPrev_r   <= csSync_r;
			sclkMeta_r <= satSclk;
			sclkSync_r <= sclkMeta_r;
			sclkPrev_r <= sclkSync_r;
			mosiMeta_r <= satMosi;
			mosiSync_r <= mosiMeta_r;
			chMeta_r   <= satChanSel;
			chSync_r   <= chMeta_r;
		end
	end

	// Buffer storage needs no reset because the counts guard every read.
	always @(posedge sys_clk) begin
		if (stgReady & stgValid & ~dDrop & (fifoCnt_r[dCh] != 2'h2))
			fifoMem_r[dSlot] <= stgData[11:0];
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r      <= ST_DRAIN;
			rx_r         <= 16'h0000;
			bitCnt_r     <= 5'h00;
			shift_r      <= 16'h0000;
			satMiso      <= 1'b0;
			frameChan_r  <= 2'h0;
			pendKind_r   <= `SCR_KIND_MCR;
			pendChan_r   <= 2'h0;
			curKind_r    <= `SCR_KIND_MCR;
			curChan_r    <= 2'h0;
			curLost_r    <= 1'b0;
			mcr_r        <= `SCR_MCR_RST;
			fifoRd_r     <= 4'h0;
			lost_r       <= 4'h0;
			globalSeen_r <= 32'h00000000;
			chanRate     <= 8'h00;
			chanFieldLen <= 8'h00;
			chanCtl      <= 8'h00;
			masterCfg    <= `SCR_MCR_RST;
			for (c = 0; c < 4; c = c + 1) begin
				ccr_r[c]     <= `SCR_CCR_RST;
				fifoCnt_r[c] <= 2'h0;
			end
		end else begin
			case (state_r)
				ST_SHIFT: begin
					if (csRise) begin
						state_r <= ST_COMMIT;
					end else if (sclkRise) begin
						rx_r <= {rx_r[14:0], mosiSync_r};
						if (bitCnt_r != 5'h1f)
							bitCnt_r <= bitCnt_r + 5'h01;
					end else if (sclkFall) begin
						shift_r <= {shift_r[14:0], 1'b0};
						satMiso <= shift_r[14];
					end
				end
				ST_COMMIT: begin
					state_r <= ST_DRAIN;
					// A frame of the wrong length writes nothing and keeps the pending reply.
					if (frameOk) begin
						if (rx_r[`SCR_SEL_BIT])
							ccr_r[frameChan_r] <= ccr_nxt;
						else if (frameChan_r == 2'h0)
							mcr_r <= rx_r[12:0];
						pendKind_r <= kind_nxt;
						pendChan_r <= frameChan_r;
					end
					for (c = 0; c < 4; c = c + 1) begin
						if (frameOk && rx_r[`SCR_SEL_BIT] && rx_r[`SCR_FLUSH_BIT] && frameChan_r == c[1:0]) begin
							fifoCnt_r[c] <= 2'h0;
						end else if (curKind_r == `SCR_KIND_FIFO && curChan_r == c[1:0] &&
							fifoCnt_r[c] != 2'h0) begin
							fifoCnt_r[c] <= fifoCnt_r[c] - 2'h1;
							fifoRd_r[c]  <= ~fifoRd_r[c];
						end
						if (curKind_r == `SCR_KIND_FIFO && curChan_r == c[1:0] && curLost_r)
							lost_r[c] <= 1'b0;
					end
				end
				ST_DRAIN: begin
					if (csFall) begin
						state_r     <= ST_SHIFT;
						bitCnt_r    <= 5'h00;
						frameChan_r <= chSync_r;
						shift_r     <= repWord;
						satMiso     <= repWord[15];
						curKind_r   <= pendKind_r;
						curChan_r   <= pendChan_r;
						curLost_r   <= lost_r[pendChan_r];
					end else if (stgValid & ~dDrop) begin
						if (stgData[14])
							globalSeen_r[stgData[4:0]] <= 1'b1;
						if (fifoCnt_r[dCh] == 2'h2)
							lost_r[dCh] <= 1'b1;
						else
							fifoCnt_r[dCh] <= fifoCnt_r[dCh] + 2'h1;
					end
				end
				default: begin
					state_r <= ST_DRAIN;
				end
			endcase
			masterCfg <= mcr_r;
			for (c = 0; c < 4; c = c + 1) begin
				chanRate[2*c +: 2] <= ccr_r[c][`SCR_RATE_HI:`SCR_RATE_LO];
				chanCtl[2*c +: 2]  <= ccr_r[c][`SCR_CTL_HI:`SCR_CTL_LO];
				if (mcr_r[`SCR_PROTO_B_LO + c])
					chanFieldLen[2*c +: 2] <= ccr_r[c][`SCR_LEN_HI:`SCR_LEN_LO];
				else
					chanFieldLen[2*c +: 2] <= `SCR_LEN_DEFAULT;
			end
		end
	end
endmodule

//--- design/scr_map.vh
// Field positions, reset values, codes and staging sizes of the satellite channel setup block.
`ifndef SCR_MAP_VH
`define SCR_MAP_VH

// Command word layout.
`define SCR_CMD_BITS       5'd16
`define SCR_SEL_BIT        14
`define SCR_FLUSH_BIT      13
`define SCR_MASK_BIT       12
`define SCR_MODE_HI        11
`define SCR_MODE_LO        10
`define SCR_RATE_HI        9
`define SCR_RATE_LO        8
`define SCR_LEN_HI         7
`define SCR_LEN_LO         6
`define SCR_CTL_HI         5
`define SCR_CTL_LO         4
`define SCR_PROTO_B_LO     8

// Write masks selected by the mask bit.
`define SCR_MASK0_BITS     14'h33ff
`define SCR_MASK1_BITS     14'h3c30

// Reset values.
`define SCR_CCR_RST        14'h0000
`define SCR_MCR_RST        13'h0000
`define SCR_LEN_DEFAULT    2'h0

// Reply modes.
`define SCR_MODE_AUTO      2'h0
`define SCR_MODE_MASTER    2'h1
`define SCR_MODE_CHANNEL   2'h2
`define SCR_MODE_FIFO      2'h3

// Reply kinds held between frames.
`define SCR_KIND_MCR       2'h0
`define SCR_KIND_CCR       2'h1
`define SCR_KIND_FILL      2'h2
`define SCR_KIND_FIFO      2'h3

// Reply words and status codes.
`define SCR_FILLER         16'he000
`define SCR_ST_OFF         2'h0
`define SCR_ST_ON_IDLE     2'h1
`define SCR_ST_ON_RUN      2'h2
`define SCR_ST_CFG         2'h3
`define SCR_EMPTY_DATA     12'h000

// Fault code range.
`define SCR_FAULT_MIN      12'h001
`define SCR_FAULT_MAX      12'h01f

// Staging buffer between the decoders and the channel buffers.
`define SCR_STG_WIDTH      15
`define SCR_STG_DEPTH      32
`define SCR_STG_AW         5

`endif

//--- design/scr_stage_fifo.v
// Staging FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module scr_stage_fifo #(
	parameter W  = 15,
	parameter D  = 32,
	parameter AW = 5
) (
	// Clock and reset.
	input  wire          clk,
	input  wire          rst_n,
	// Filling side.
	input  wire          inValid,
	output reg           inReady,
	input  wire [W-1:0]  inData,
	// Draining side.
	output wire          outValid,
	input  wire          outReady,
	output wire [W-1:0]  outData
);
	localparam [AW:0] FULL_CNT = D;
	localparam [AW:0] ONE_CNT  = 1;

	reg  [W-1:0]  mem [0:D-1];
	reg  [AW-1:0] wrPtr_r;
	reg  [AW-1:0] rdPtr_r;
	reg  [AW:0]   count_r;
	reg  [AW:0]   count_nxt;
	wire          doPush;
	wire          doPop;

	assign outValid = (count_r != {(AW+1){1'b0}});
	assign outData  = mem[rdPtr_r];
	assign doPush   = inValid & inReady;
	assign doPop    = outReady & outValid;

	always @* begin
		count_nxt = count_r;
		if (doPush & ~doPop)
			count_nxt = count_r + ONE_CNT;
		else if (doPop & ~doPush)
			count_nxt = count_r - ONE_CNT;
	end

	always @(posedge clk) begin
		if (doPush)
			mem[wrPtr_r] <= inData;
	end

	// Ready is registered so the source sees a clean flop and full can never be overrun.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_r <= {AW{1'b0}};
			rdPtr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
			inReady <= 1'b1;
		end else begin
			if (doPush)
				wrPtr_r <= wrPtr_r + 1'b1;
			if (doPop)
				rdPtr_r <= rdPtr_r + 1'b1;
			count_r <= count_nxt;
			inReady <= (count_nxt != FULL_CNT);
		end
	end
endmodule

//--- tb/scr_channel_config_bench.sv
// Self-checking bench for the satellite channel setup block.
`timescale 1ns/100ps
module scr_channel_config_bench;
	reg         sys_clk;
	reg         rst_n;
	wire        satCsN;
	wire        satSclk;
	wire        satMosi;
	wire [1:0]  satChanSel;
	wire        satMiso;
	reg         faultValid;
	reg         faultGlobal;
	reg  [1:0]  faultChan;
	reg  [11:0] faultCode;
	wire        faultReady;
	wire [7:0]  chanRate;
	wire [7:0]  chanFieldLen;
	wire [7:0]  chanCtl;
	wire [12:0] masterCfg;
	integer     n_mismatch;
	integer     cmp_count;
	reg  [15:0] rsp;

	scr_channel_config u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .satCsN(satCsN), .satSclk(satSclk),
		.satMosi(satMosi), .satChanSel(satChanSel), .satMiso(satMiso), .faultValid(faultValid),
		.faultGlobal(faultGlobal), .faultChan(faultChan), .faultCode(faultCode), .faultReady(faultReady),
		.chanRate(chanRate), .chanFieldLen(chanFieldLen), .chanCtl(chanCtl), .masterCfg(masterCfg));
	scr_spi_host u_host (.satCsN(satCsN), .satSclk(satSclk), .satMosi(satMosi), .satChanSel(satChanSel),
		.satMiso(satMiso));

	initial sys_clk = 1'b0;
	always #2 sys_clk = ~sys_clk;

	task conclude;
		begin
			if (n_mismatch == 0 && cmp_count > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask

	task check(input [15:0] got, input [15:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("Error %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask

	function [15:0] par(input [15:0] w);
		begin
			par = w;
			par[13] = ~^{w[15:14], w[12:0]};
		end
	endfunction

	function [15:0] cfg(input [12:0] v);
		cfg = par({3'b110, v});
	endfunction

	function [15:0] fif(input [1:0] s, input l, input [11:0] d);
		fif = par({s, 1'b0, l, d});
	endfunction

	// The reply seen in a frame answers the frame before it.
	task fr(input [15:0] cmd, input [1:0] ch, input [15:0] exp);
		begin
			u_host.xfer(cmd, ch, rsp);
			check(rsp, exp);
		end
	endtask

	// Must be entered just after a clock edge; the caller lowers the valid after a batch.
	task push(input g, input [1:0] c, input [11:0] d);
		begin
			faultValid <= 1'b1;
			faultGlobal <= g;
			faultChan <= c;
			faultCode <= d;
			@(posedge sys_clk);
			while (faultReady !== 1'b1) @(posedge sys_clk);
		end
	endtask

	initial begin
		#200000;
		n_mismatch = n_mismatch + 1;
		conclude;
	end

	initial begin
		n_mismatch = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		faultValid = 1'b0;
		faultGlobal = 1'b0;
		faultChan = 2'h0;
		faultCode = 12'h000;
		repeat (2) @(posedge sys_clk);
		check({chanRate, chanFieldLen}, 16'h0000);
		rst_n <= 1'b1;
		fr(16'h43a5, 2'h0, cfg(13'h0000));
		check({chanRate, chanCtl}, 16'h0302);
		check({8'h00, chanFieldLen}, 16'h0000);
		fr(16'h0100, 2'h0, cfg(13'h03a5));
		check({chanFieldLen, masterCfg[7:0]}, 16'h0200);
		fr(16'h5810, 2'h0, cfg(13'h0100));
		check({chanRate, chanCtl}, 16'h0301);
		fr(16'h5400, 2'h1, cfg(13'h1b95));
		fr(16'h5410, 2'h0, 16'he000);
		fr(16'h0000, 2'h2, cfg(13'h0100));
		check({3'h0, masterCfg}, 16'h0100);
		fr(16'h5c20, 2'h1, 16'he000);
		@(posedge sys_clk);
		push(1'b0, 2'h1, 12'h019);
		push(1'b0, 2'h1, 12'h01a);
		push(1'b0, 2'h1, 12'h01c);
		faultValid <= 1'b0;
		repeat (20) @(posedge sys_clk);
		fr(16'h5c20, 2'h1, fif(2'h2, 1'b1, 12'h019));
		fr(16'h5c20, 2'h1, fif(2'h2, 1'b0, 12'h01a));
		fr(16'h5c20, 2'h1, fif(2'h2, 1'b0, 12'h000));
		@(posedge sys_clk);
		push(1'b0, 2'h1, 12'h011);
		push(1'b0, 2'h1, 12'h012);
		faultValid <= 1'b0;
		repeat (20) @(posedge sys_clk);
		fr(16'h7c20, 2'h1, fif(2'h2, 1'b0, 12'h011));
		fr(16'h5c10, 2'h0, fif(2'h2, 1'b0, 12'h000));
		@(posedge sys_clk);
		push(1'b1, 2'h2, 12'h002);
		push(1'b1, 2'h3, 12'h002);
		push(1'b1, 2'h0, 12'h020);
		faultValid <= 1'b0;
		repeat (20) @(posedge sys_clk);
		fr(16'h5c10, 2'h0, fif(2'h1, 1'b0, 12'h002));
		fork
			fr(16'h5c30, 2'h3, fif(2'h1, 1'b0, 12'h000));
			begin
				#300;
				@(posedge sys_clk);
				faultValid <= 1'b1;
				faultGlobal <= 1'b0;
				faultChan <= 2'h3;
				faultCode <= 12'h010;
				repeat (40) @(posedge sys_clk);
				#1 check({15'h0000, faultReady}, 16'h0000);
				@(posedge sys_clk);
				faultValid <= 1'b0;
			end
		join
		fr(16'h5c30, 2'h3, fif(2'h0, 1'b1, 12'h010));
		conclude;
	end
endmodule

//--- tb/scr_properties.sv
// Checker on the ports of the satellite channel setup block.
`timescale 1ns/100ps
module scr_properties (
	// Clock and reset.
	input wire        sys_clk,
	input wire        rst_n,
	// Serial port.
	input wire        satCsN,
	input wire        satSclk,
	input wire        satMosi,
	input wire [1:0]  satChanSel,
	input wire        satMiso,
	// Fault stream.
	input wire        faultValid,
	input wire        faultGlobal,
	input wire [1:0]  faultChan,
	input wire [11:0] faultCode,
	input wire        faultReady,
	// Settings.
	input wire [7:0]  chanRate,
	input wire [7:0]  chanFieldLen,
	input wire [7:0]  chanCtl,
	input wire [12:0] masterCfg
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Staging may only drain while chip select is high, so the wait is counted from a quiet stream.
	sequence s_stall;
		!faultReady && !faultValid ##1 (satCsN && !faultValid) [*8];
	endsequence
	property p_rst_cfg;
		$rose(rst_n) |-> chanRate == 8'h00 && chanFieldLen == 8'h00 && chanCtl == 8'h00 && masterCfg == 13'h0000;
	endproperty
	a_rst_cfg: assert property (p_rst_cfg) else $error("settings not cleared");
	property p_rst_io;
		$rose(rst_n) |-> !satMiso && faultReady;
	endproperty
	a_rst_io: assert property (p_rst_io) else $error("reply or ready wrong after reset");
	property p_len_gate;
		(chanFieldLen & ~{{2{masterCfg[11]}}, {2{masterCfg[10]}}, {2{masterCfg[9]}}, {2{masterCfg[8]}}}) == 8'h00;
	endproperty
	a_len_gate: assert property (p_len_gate) else $error("field length on non B channel");
	property p_cfg_commit;
		$changed({chanRate, chanCtl, masterCfg}) |-> satCsN && $past(satCsN, 2);
	endproperty
	a_cfg_commit: assert property (p_cfg_commit) else $error("settings changed inside frame");
	property p_master_ch1;
		$changed(masterCfg) |-> satChanSel == 2'h0;
	endproperty
	a_master_ch1: assert property (p_master_ch1) else $error("master written from channel 2-4");
	property p_miso_edge;
		$changed(satMiso) |-> !satSclk && !$past(satSclk, 2);
	endproperty
	a_miso_edge: assert property (p_miso_edge) else $error("reply bit moved with clock high");
	property p_ready_fall;
		$fell(faultReady) |-> $past(faultValid);
	endproperty
	a_ready_fall: assert property (p_ready_fall) else $error("ready fell without push");
	property p_ready_back;
		s_stall |-> faultReady;
	endproperty
	a_ready_back: assert property (p_ready_back) else $error("staging did not drain");
endmodule

bind scr_channel_config scr_properties u_props (.sys_clk(sys_clk), .rst_n(rst_n), .satCsN(satCsN),
	.satSclk(satSclk), .satMosi(satMosi), .satChanSel(satChanSel), .satMiso(satMiso),
	.faultValid(faultValid), .faultGlobal(faultGlobal), .faultChan(faultChan), .faultCode(faultCode),
	.faultReady(faultReady), .chanRate(chanRate), .chanFieldLen(chanFieldLen), .chanCtl(chanCtl),
	.masterCfg(masterCfg));

//--- tb/scr_spi_host.sv
// Microcontroller model running 16-bit frames on the satellite serial port.
`timescale 1ns/100ps
module scr_spi_host (
	// Serial port.
	output reg       satCsN,
	output reg       satSclk,
	output reg       satMosi,
	output reg [1:0] satChanSel,
	input wire       satMiso
);
	initial begin
		satCsN = 1'b1;
		satSclk = 1'b0;
		satMosi = 1'b0;
		satChanSel = 2'h0;
	end
	// The clock stands still between frames and the released data line shows the inverse of its last bit.
	task xfer(input [15:0] cmd, input [1:0] ch, output [15:0] rsp);
		integer i;
		begin
			satChanSel <= ch;
			#20 satCsN <= 1'b0;
			#100;
			for (i = 15; i >= 0; i = i - 1) begin
				satMosi <= cmd[i];
				#62.5 satSclk <= 1'b1;
				rsp[i] = satMiso;
				#62.5 satSclk <= 1'b0;
			end
			#100 satCsN <= 1'b1;
			satMosi <= ~satMosi;
			#100;
		end
	endtask
endmodule
